// File: fewss_top.sv
// Sequencer for block erase, chip erase and byte write; block erase and byte write can be suspended, chip erase cannot.
// Assumes command writes arrive as one-cycle strobes already in the
// clock domain; the array itself is outside, driven by the op outputs.
`timescale 1ns/1ps
`default_nettype none
module fewss_top #(
   parameter logic [7:0] SUSPEND_CODE = fewss_pkg::CMD_SUSPEND_DEF,
   parameter int ERASE_CYCLES = fewss_pkg::ERASE_CYC,
   parameter int WRITE_CYCLES = fewss_pkg::WRITE_CYC
) (
   input wire logic i_ref_clk,
   input wire logic i_arst_n,
   input wire logic i_cmd_we,
   input wire fewss_pkg::fewss_cmd_t i_cmd,
   input wire logic i_supply_ok,
   input wire logic i_boot_guard,
   input wire logic [fewss_pkg::NUM_BLOCKS-1:0] i_block_lock,
   input wire logic [7:0] i_array_rdata,
   output logic [7:0] o_status,
   output logic o_status_mode,
   output logic o_erase_pulse,
   output logic [fewss_pkg::BLK_W-1:0] o_erase_block,
   output logic o_write_pulse,
   output logic [19:0] o_write_addr,
   output logic [7:0] o_write_data
);
   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [1:0] sup_sync_ff, grd_sync_ff;
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sup_sync_ff <= 2'h0;
         grd_sync_ff <= 2'h0;
      end else begin
         sup_sync_ff <= {sup_sync_ff[0], i_supply_ok};
         grd_sync_ff <= {grd_sync_ff[0], i_boot_guard};
      end
   end
   wire logic supply_ok = sup_sync_ff[1];
   wire logic guard_hi = grd_sync_ff[1];
   // ****************************************************************
   // Block decode
   // ****************************************************************
   function automatic logic [fewss_pkg::BLK_W-1:0] blk_of(input logic [19:0] a);
      // Eight 8K blocks at bottom, then 64K main blocks
      if (a[19:16] == 4'h0) blk_of = {2'h0, a[15:13]};
      else blk_of = 5'(a[19:16]) + 5'h07;
   endfunction
   function automatic logic blk_locked(input logic [fewss_pkg::BLK_W-1:0] b,
                                        input logic [fewss_pkg::NUM_BLOCKS-1:0] lk,
                                        input logic g);
      blk_locked = lk[b] || (b < 5'(fewss_pkg::NUM_BOOT) && !g);
   endfunction
   // ****************************************************************
   // Sequencer state
   // ****************************************************************
   fewss_pkg::fewss_state_t st_ff, nxt_st;
   fewss_pkg::fewss_mode_t mode_ff, nxt_mode;
   logic [7:0] setup_ff, nxt_setup;
   logic [7:0] status_ff, nxt_status;
   logic [fewss_pkg::CNT_W-1:0] ecnt_ff, nxt_ecnt, wcnt_ff, nxt_wcnt;
   logic [fewss_pkg::BLK_W-1:0] eblk_ff, nxt_eblk;
   logic chip_ff, nxt_chip, esusp_req_ff, nxt_esusp_req, wsusp_req_ff, nxt_wsusp_req;
   logic nested_ff, nxt_nested, epulse_ff, nxt_epulse, wpulse_ff, nxt_wpulse;
   logic [19:0] waddr_ff, nxt_waddr;
   logic [7:0] wdata_ff, nxt_wdata;
   logic [7:0] c;
   logic [fewss_pkg::BLK_W-1:0] cblk;
   logic any_unlocked;

   always_comb begin
      c = i_cmd.data;
      cblk = blk_of(i_cmd.addr);
      any_unlocked = 1'b0;
      for (int b = 0; b < fewss_pkg::NUM_BLOCKS; b++)
         if (!blk_locked(5'(b), i_block_lock, guard_hi)) any_unlocked = 1'b1;
      nxt_st = st_ff;
      nxt_mode = mode_ff;
      nxt_setup = setup_ff;
      nxt_status = status_ff;
      nxt_ecnt = ecnt_ff;
      nxt_wcnt = wcnt_ff;
      nxt_eblk = eblk_ff;
      nxt_chip = chip_ff;
      nxt_esusp_req = esusp_req_ff;
      nxt_wsusp_req = wsusp_req_ff;
      nxt_nested = nested_ff;
      nxt_epulse = 1'b0;
      nxt_wpulse = 1'b0;
      nxt_waddr = waddr_ff;
      nxt_wdata = wdata_ff;
      // ---------------- Internal progress ----------------
      unique case (st_ff)
         fewss_pkg::FEWSS_ERASE: begin
            if (esusp_req_ff && !chip_ff && ecnt_ff[3:0] == 4'h0) begin
               nxt_st = fewss_pkg::FEWSS_ESUSP;
               nxt_esusp_req = 1'b0;
               nxt_status[fewss_pkg::SB_READY] = 1'b1;
               nxt_status[fewss_pkg::SB_ERS_SUSP] = 1'b1;
            end else if (ecnt_ff != '0) begin
               nxt_ecnt = ecnt_ff - 1'b1;
            end else if (chip_ff && eblk_ff != 5'(fewss_pkg::NUM_BLOCKS - 1)) begin
               nxt_eblk = eblk_ff + 1'b1;
               nxt_ecnt = blk_locked(eblk_ff + 1'b1, i_block_lock, guard_hi) ?
                          '0 : fewss_pkg::CNT_W'(ERASE_CYCLES);
               nxt_epulse = !blk_locked(eblk_ff + 1'b1, i_block_lock, guard_hi);
            end else begin
               nxt_st = fewss_pkg::FEWSS_IDLE;
               nxt_esusp_req = 1'b0;
               nxt_status[fewss_pkg::SB_READY] = 1'b1;
            end
         end
         fewss_pkg::FEWSS_WRITE: begin
            if (wsusp_req_ff && wcnt_ff[3:0] == 4'h0 && wcnt_ff != '0) begin
               nxt_st = fewss_pkg::FEWSS_WSUSP;
               nxt_wsusp_req = 1'b0;
               nxt_status[fewss_pkg::SB_READY] = 1'b1;
               nxt_status[fewss_pkg::SB_WR_SUSP] = 1'b1;
            end else if (wcnt_ff != '0) begin
               nxt_wcnt = wcnt_ff - 1'b1;
            end else begin
               nxt_wsusp_req = 1'b0;
               nxt_wpulse = 1'b1;
               // Only zeros requested but still one are failures
               if ((~wdata_ff & i_array_rdata) != 8'h00)
                  nxt_status[fewss_pkg::SB_WR_ERR] = 1'b1;
               nxt_status[fewss_pkg::SB_READY] = 1'b1;
               nxt_st = nested_ff ? fewss_pkg::FEWSS_ESUSP : fewss_pkg::FEWSS_IDLE;
               nxt_nested = 1'b0;
            end
         end
         default: ;
      endcase
      // ---------------- Command decode ----------------
      if (i_cmd_we) begin
         if (mode_ff == fewss_pkg::FEWSS_MODE_SETUP) begin
            nxt_mode = fewss_pkg::FEWSS_MODE_STATUS;
            if (setup_ff == fewss_pkg::CMD_WRITE_STD || setup_ff == fewss_pkg::CMD_WRITE_ALT) begin
               if (!supply_ok) begin
                  nxt_status[fewss_pkg::SB_SUP_LOW] = 1'b1;
                  nxt_status[fewss_pkg::SB_WR_ERR] = 1'b1;
               end else if (blk_locked(cblk, i_block_lock, guard_hi) ||
                            (st_ff == fewss_pkg::FEWSS_ESUSP && cblk == eblk_ff)) begin
                  nxt_status[fewss_pkg::SB_LOCK_VIO] = 1'b1;
                  nxt_status[fewss_pkg::SB_WR_ERR] = 1'b1;
               end else begin
                  nxt_nested = (st_ff == fewss_pkg::FEWSS_ESUSP);
                  nxt_st = fewss_pkg::FEWSS_WRITE;
                  nxt_wcnt = fewss_pkg::CNT_W'(WRITE_CYCLES);
                  nxt_waddr = i_cmd.addr;
                  nxt_wdata = c;
                  nxt_status[fewss_pkg::SB_READY] = 1'b0;
               end
            end else if (c != fewss_pkg::CMD_CONFIRM) begin
               nxt_status[fewss_pkg::SB_WR_ERR] = 1'b1;
               nxt_status[fewss_pkg::SB_ERS_ERR] = 1'b1;
            end else if (!supply_ok) begin
               nxt_status[fewss_pkg::SB_SUP_LOW] = 1'b1;
               nxt_status[fewss_pkg::SB_ERS_ERR] = 1'b1;
            end else if (setup_ff == fewss_pkg::CMD_CHIP_ERASE) begin
               if (!any_unlocked) begin
                  nxt_status[fewss_pkg::SB_LOCK_VIO] = 1'b1;
                  nxt_status[fewss_pkg::SB_ERS_ERR] = 1'b1;
               end else begin
                  nxt_st = fewss_pkg::FEWSS_ERASE;
                  nxt_chip = 1'b1;
                  nxt_eblk = '0;
                  nxt_epulse = !blk_locked('0, i_block_lock, guard_hi);
                  nxt_ecnt = nxt_epulse ? fewss_pkg::CNT_W'(ERASE_CYCLES) : '0;
                  nxt_status[fewss_pkg::SB_READY] = 1'b0;
               end
            end else if (blk_locked(cblk, i_block_lock, guard_hi)) begin
               nxt_status[fewss_pkg::SB_LOCK_VIO] = 1'b1;
               nxt_status[fewss_pkg::SB_ERS_ERR] = 1'b1;
            end else begin
               nxt_st = fewss_pkg::FEWSS_ERASE;
               nxt_chip = 1'b0;
               nxt_eblk = cblk;
               nxt_epulse = 1'b1;
               nxt_ecnt = fewss_pkg::CNT_W'(ERASE_CYCLES);
               nxt_status[fewss_pkg::SB_READY] = 1'b0;
            end
         end else if (c == fewss_pkg::CMD_READ_STATUS) begin
            nxt_mode = fewss_pkg::FEWSS_MODE_STATUS;
         end else if (st_ff == fewss_pkg::FEWSS_ERASE || st_ff == fewss_pkg::FEWSS_WRITE) begin
            if (c == SUSPEND_CODE) begin
               nxt_mode = fewss_pkg::FEWSS_MODE_STATUS;
               if (st_ff == fewss_pkg::FEWSS_WRITE) nxt_wsusp_req = 1'b1;
               else if (!chip_ff) nxt_esusp_req = 1'b1;
            end
            // Anything else is dropped while busy
         end else if (c == SUSPEND_CODE) begin
            if (st_ff == fewss_pkg::FEWSS_IDLE) nxt_mode = fewss_pkg::FEWSS_MODE_ARRAY;
         end else if (c == fewss_pkg::CMD_CONFIRM &&
                      (st_ff == fewss_pkg::FEWSS_ESUSP || st_ff == fewss_pkg::FEWSS_WSUSP)) begin
            nxt_mode = fewss_pkg::FEWSS_MODE_STATUS;
            nxt_status[fewss_pkg::SB_READY] = 1'b0;
            if (st_ff == fewss_pkg::FEWSS_WSUSP) begin
               nxt_st = fewss_pkg::FEWSS_WRITE;
               nxt_status[fewss_pkg::SB_WR_SUSP] = 1'b0;
            end else begin
               nxt_st = fewss_pkg::FEWSS_ERASE;
               nxt_status[fewss_pkg::SB_ERS_SUSP] = 1'b0;
            end
         end else if (c == fewss_pkg::CMD_READ_ARRAY) begin
            nxt_mode = fewss_pkg::FEWSS_MODE_ARRAY;
         end else if (st_ff == fewss_pkg::FEWSS_IDLE && c == fewss_pkg::CMD_CLEAR_STATUS) begin
            nxt_status[fewss_pkg::SB_ERS_ERR] = 1'b0;
            nxt_status[fewss_pkg::SB_WR_ERR] = 1'b0;
            nxt_status[fewss_pkg::SB_SUP_LOW] = 1'b0;
            nxt_status[fewss_pkg::SB_LOCK_VIO] = 1'b0;
         end else if ((st_ff == fewss_pkg::FEWSS_IDLE &&
                       (c == fewss_pkg::CMD_BLOCK_ERASE || c == fewss_pkg::CMD_CHIP_ERASE)) ||
                      (st_ff != fewss_pkg::FEWSS_WSUSP &&
                       (c == fewss_pkg::CMD_WRITE_STD || c == fewss_pkg::CMD_WRITE_ALT))) begin
            nxt_mode = fewss_pkg::FEWSS_MODE_SETUP;
            nxt_setup = c;
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st_ff <= fewss_pkg::FEWSS_IDLE;
         mode_ff <= fewss_pkg::FEWSS_MODE_ARRAY;
         setup_ff <= 8'h00;
         status_ff <= 8'h80;
         ecnt_ff <= '0;
         wcnt_ff <= '0;
         eblk_ff <= '0;
         chip_ff <= 1'b0;
         esusp_req_ff <= 1'b0;
         wsusp_req_ff <= 1'b0;
         nested_ff <= 1'b0;
         epulse_ff <= 1'b0;
         wpulse_ff <= 1'b0;
         waddr_ff <= 20'h00000;
         wdata_ff <= 8'h00;
      end else begin
         st_ff <= nxt_st;
         mode_ff <= nxt_mode;
         setup_ff <= nxt_setup;
         status_ff <= nxt_status;
         ecnt_ff <= nxt_ecnt;
         wcnt_ff <= nxt_wcnt;
         eblk_ff <= nxt_eblk;
         chip_ff <= nxt_chip;
         esusp_req_ff <= nxt_esusp_req;
         wsusp_req_ff <= nxt_wsusp_req;
         nested_ff <= nxt_nested;
         epulse_ff <= nxt_epulse;
         wpulse_ff <= nxt_wpulse;
         waddr_ff <= nxt_waddr;
         wdata_ff <= nxt_wdata;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign o_status = status_ff;
   assign o_status_mode = (mode_ff != fewss_pkg::FEWSS_MODE_ARRAY);
   assign o_erase_pulse = epulse_ff;
   assign o_erase_block = eblk_ff;
   assign o_write_pulse = wpulse_ff;
   assign o_write_addr = waddr_ff;
   assign o_write_data = wdata_ff;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   property p_busy_not_ready;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      (st_ff == fewss_pkg::FEWSS_ERASE) |-> !status_ff[fewss_pkg::SB_READY];
   endproperty
   a_busy_not_ready: assert property (p_busy_not_ready) else $error("ready while erasing");
   property p_esusp_bits;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      (st_ff == fewss_pkg::FEWSS_ESUSP) |-> status_ff[fewss_pkg::SB_ERS_SUSP];
   endproperty
   a_esusp_bits: assert property (p_esusp_bits) else $error("suspend bit low");
   property p_chip_no_susp;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      chip_ff |-> st_ff != fewss_pkg::FEWSS_ESUSP;
   endproperty
   a_chip_no_susp: assert property (p_chip_no_susp) else $error("chip erase suspended");
   property p_err_sticky;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      status_ff[fewss_pkg::SB_ERS_ERR] && !(i_cmd_we && i_cmd.data == fewss_pkg::CMD_CLEAR_STATUS)
      |=> status_ff[fewss_pkg::SB_ERS_ERR];
   endproperty
   a_err_sticky: assert property (p_err_sticky) else $error("error bit lost");
   property p_bad_confirm;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      i_cmd_we && mode_ff == fewss_pkg::FEWSS_MODE_SETUP && setup_ff == fewss_pkg::CMD_BLOCK_ERASE
      && i_cmd.data != fewss_pkg::CMD_CONFIRM |=> status_ff[5] && status_ff[4];
   endproperty
   a_bad_confirm: assert property (p_bad_confirm) else $error("bad confirm unflagged");
   property p_nested_hold;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      nested_ff |-> status_ff[fewss_pkg::SB_ERS_SUSP] && st_ff != fewss_pkg::FEWSS_ERASE;
   endproperty
   a_nested_hold: assert property (p_nested_hold) else $error("erase during nested write");
   property p_wsusp_bits;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      $rose(st_ff == fewss_pkg::FEWSS_WSUSP) |-> status_ff[7] && status_ff[2];
   endproperty
   a_wsusp_bits: assert property (p_wsusp_bits) else $error("write suspend bits");
   property p_lowsup_write;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      i_cmd_we && mode_ff == fewss_pkg::FEWSS_MODE_SETUP && !supply_ok
      |=> st_ff != fewss_pkg::FEWSS_WRITE || $past(st_ff) == fewss_pkg::FEWSS_WRITE;
   endproperty
   a_lowsup_write: assert property (p_lowsup_write) else $error("write under lockout");
   c_erase: cover property (@(posedge i_ref_clk) st_ff == fewss_pkg::FEWSS_ERASE);
   c_esusp: cover property (@(posedge i_ref_clk) st_ff == fewss_pkg::FEWSS_ESUSP);
   c_nested: cover property (@(posedge i_ref_clk) nested_ff);
   c_wsusp: cover property (@(posedge i_ref_clk) st_ff == fewss_pkg::FEWSS_WSUSP);
endmodule
`default_nettype wire

// File: fewss_pkg.sv
// Package for the flash erase/write/suspend sequencer: command codes,
// status bit positions, block map, state encoding and timing counts.
// Assumes a single 25 MHz clock and a synchronous command strobe.
package fewss_pkg;
   // ****************************************************************
   // Command codes
   // ****************************************************************
   localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_BLOCK_ERASE = 8'h20;
   localparam logic [7:0] CMD_CHIP_ERASE = 8'h30;
   localparam logic [7:0] CMD_CONFIRM = 8'hD0;
   localparam logic [7:0] CMD_WRITE_STD = 8'h40;
   localparam logic [7:0] CMD_WRITE_ALT = 8'h10;
   // Suspend code value is arbitrary here; it is a parameter of the top
   localparam logic [7:0] CMD_SUSPEND_DEF = 8'hA5;
   // ****************************************************************
   // Status bit positions
   // ****************************************************************
   localparam int SB_READY = 7;
   localparam int SB_ERS_SUSP = 6;
   localparam int SB_ERS_ERR = 5;
   localparam int SB_WR_ERR = 4;
   localparam int SB_SUP_LOW = 3;
   localparam int SB_WR_SUSP = 2;
   localparam int SB_LOCK_VIO = 1;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   // ****************************************************************
   // Block map and timing
   // ****************************************************************
   localparam int NUM_BLOCKS = 23;
   localparam int BLK_W = 5;
   localparam int NUM_BOOT = 2;
   localparam int CLK_MHZ = 25;
   localparam int ERASE_US = 40;
   localparam int WRITE_US = 4;
   localparam int ERASE_CYC = ERASE_US * CLK_MHZ;
   localparam int WRITE_CYC = WRITE_US * CLK_MHZ;
   localparam int SUSP_STEP = 16;
   localparam int CNT_W = 16;
   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [2:0] {
      FEWSS_IDLE = 3'b000,
      FEWSS_ERASE = 3'b001,
      FEWSS_ESUSP = 3'b011,
      FEWSS_WRITE = 3'b010,
      FEWSS_WSUSP = 3'b110
   } fewss_state_t;
   typedef enum logic [1:0] {
      FEWSS_MODE_ARRAY = 2'b00,
      FEWSS_MODE_STATUS = 2'b01,
      FEWSS_MODE_SETUP = 2'b11
   } fewss_mode_t;
   typedef struct packed {
      logic [19:0] addr;
      logic [7:0] data;
   } fewss_cmd_t;
endpackage

// File: fewss_array_model.sv
// Behavioural byte array on the far side of the sequencer.
// Assumes registered one-cycle pulses from the sequencer, same clock.
`timescale 1ns/1ps
`default_nettype none
module fewss_array_model (
   input wire logic i_ref_clk,
   input wire logic i_erase_pulse,
   input wire logic i_write_pulse,
   input wire logic [19:0] i_addr,
   input wire logic [7:0] i_data,
   input wire logic [7:0] i_stuck,
   output logic [7:0] o_rdata
);
   logic [7:0] mem [256];
   initial foreach (mem[i]) mem[i] = 8'hFF;
   // Programmed result as verify sees it; stuck bits stay one
   assign o_rdata = (mem[i_addr[7:0]] & i_data) | i_stuck;
   always @(posedge i_ref_clk) begin
      if (i_erase_pulse) begin
         foreach (mem[i]) mem[i] <= 8'hFF;
      end else if (i_write_pulse) begin
         mem[i_addr[7:0]] <= o_rdata;
      end
   end
endmodule
`default_nettype wire

// File: flash_erase_write_suspend_sequencer_tb.sv
// Self-checking bench for the erase/write/suspend sequencer.
// Assumes the package, the sequencer top and the array model.
`timescale 1ns/1ps
`default_nettype none
module flash_erase_write_suspend_sequencer_tb;
   localparam logic [7:0] SUSP = fewss_pkg::CMD_SUSPEND_DEF;
   logic clk = 0, rst_n = 0, we = 0, sup = 1, grd = 1;
   logic [22:0] lk = '0;
   logic [7:0] stuck = 8'h00, rd, st, wd, eb, d;
   logic [19:0] wa, a;
   logic [31:0] e;
   fewss_pkg::fewss_cmd_t cmd = '0;
   logic mode, ep, wp;
   logic [4:0] blk;
   int failures = 0, n_checks = 0, n_ers = 0, n_wr = 0, cyc = 0, seed;
   logic [4:0] blk_q[$];
   logic [31:0] tbl [9] = '{32'h20FF3003, 32'h20D02802, 32'h20D02211, 32'h20D0220B,
      32'h30FF3003, 32'h30D02802, 32'h30D02207, 32'h40001802, 32'h1000120B};
   fewss_top #(.SUSPEND_CODE(SUSP), .ERASE_CYCLES(40), .WRITE_CYCLES(20)) dut (
      .i_ref_clk(clk), .i_arst_n(rst_n), .i_cmd_we(we), .i_cmd(cmd), .i_supply_ok(sup),
      .i_boot_guard(grd), .i_block_lock(lk), .i_array_rdata(rd), .o_status(st),
      .o_status_mode(mode), .o_erase_pulse(ep), .o_erase_block(blk), .o_write_pulse(wp),
      .o_write_addr(wa), .o_write_data(wd));
   fewss_array_model arr (.i_ref_clk(clk), .i_erase_pulse(ep), .i_write_pulse(wp),
      .i_addr(wa), .i_data(wd), .i_stuck(stuck), .o_rdata(rd));
   initial begin
      forever #20 clk = ~clk;
   end
   // ****************************************************************
   // Monitor and helpers
   // ****************************************************************
   always @(posedge clk) begin
      cyc++;
      if (ep === 1'b1) begin
         n_ers++;
         blk_q.push_back(blk);
      end
      if (wp === 1'b1) n_wr++;
      if (cyc == 20000) begin
         failures++;
         print_verdict();
      end
   end
   function automatic logic [19:0] blk_base(input logic [7:0] b);
      // Boot and parameter blocks are 8K, main blocks 64K
      if (b < 8'h08) return 20'(b) << 13;
      return 20'(b - 8'h07) << 16;
   endfunction
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] dt, input logic [19:0] ad);
      @(negedge clk);
      we = 1;
      cmd = '{addr: ad, data: dt};
      @(negedge clk);
      we = 0;
   endtask
   task automatic wait_rdy();
      int k = 0;
      repeat (2) @(negedge clk);
      while (st[7] !== 1'b1 && k < 400) begin
         @(negedge clk);
         k++;
      end
      // One more cycle so the monitor has counted the closing pulse
      @(negedge clk);
   endtask
   task automatic print_verdict();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ****************************************************************
   // Tests
   // ****************************************************************
   initial begin
      seed = 59528;
      repeat (3) @(negedge clk);
      rst_n = 1;
      repeat (2) @(negedge clk);
      eb = 8'(2 + ($unsigned($random(seed)) % 21));
      a = blk_base(eb);
      wr(8'h20, a);
      wr(8'hD0, a | 20'h00123);
      @(negedge clk);
      chk(st & 8'h80, 8'h00);
      wr(8'hFF, 20'h0);
      chk({7'h0, mode}, 8'h01);
      wait_rdy();
      chk(st, 8'h80);
      chk({7'h0, mode}, 8'h01);
      chk(8'(n_ers), 8'h01);
      chk({3'h0, blk_q[0]}, eb);
      wr(SUSP, 20'h0);
      repeat (2) @(negedge clk);
      chk({7'h0, mode}, 8'h00);
      $display("test block erase done");
      for (int i = 0; i < 9; i++) begin
         e = tbl[i];
         sup = e[0];
         grd = e[1];
         lk = e[2] ? '1 : (e[3] ? 23'h000020 : '0);
         a = e[4] ? 20'h00100 : 20'h0A010;
         repeat (3) @(negedge clk);
         n_ers = 0;
         n_wr = 0;
         wr(e[31:24], a);
         wr(e[23:16], a);
         wait_rdy();
         chk(st & 8'h3E, e[15:8]);
         chk(8'(n_ers + n_wr), 8'h00);
         wr(8'hFF, a);
         @(negedge clk);
         chk(st & 8'h3E, e[15:8]);
         wr(8'h50, a);
         repeat (2) @(negedge clk);
         chk(st & 8'h3E, 8'h00);
      end
      sup = 1;
      grd = 1;
      lk = '0;
      $display("test error table done");
      for (int i = 0; i < 3; i++) begin
         a = 20'h90000 | 20'($unsigned($random(seed)) & 32'hFFFF);
         d = 8'($random(seed));
         if (i == 2) begin
            stuck = 8'h01;
            d[0] = 1'b0;
         end
         n_wr = 0;
         wr(i == 1 ? 8'h10 : 8'h40, a);
         wr(d, a);
         wait_rdy();
         chk(8'(n_wr), 8'h01);
         chk({7'h0, wa === a && wd === d}, 8'h01);
         chk(st & 8'h90, i == 2 ? 8'h90 : 8'h80);
         stuck = 8'h00;
         wr(8'h50, a);
      end
      $display("test byte write done");
      wr(8'h20, 20'h08000);
      wr(8'hD0, 20'h08000);
      wr(SUSP, 20'h0);
      wait_rdy();
      chk(st & 8'hC4, 8'hC0);
      a = 20'hC0000 | 20'($unsigned($random(seed)) & 32'hFFFF);
      wr(8'h40, a);
      wr(8'h5A, a);
      repeat (2) @(negedge clk);
      chk(st & 8'hC0, 8'h40);
      wait_rdy();
      chk(st & 8'hC2, 8'hC0);
      wr(8'h40, 20'h08010);
      wr(8'h00, 20'h08010);
      wait_rdy();
      chk(st & 8'h42, 8'h42);
      wr(8'hD0, 20'h0);
      repeat (2) @(negedge clk);
      chk(st & 8'hC0, 8'h00);
      wait_rdy();
      chk(st & 8'h7C, 8'h10);
      wr(8'h50, 20'h0);
      $display("test erase suspend done");
      n_wr = 0;
      wr(8'h40, 20'hA0000);
      wr(8'h3C, 20'hA0000);
      wr(SUSP, 20'h0);
      wait_rdy();
      chk(st & 8'h84, 8'h84);
      chk(8'(n_wr), 8'h00);
      wr(8'hD0, 20'h0);
      repeat (2) @(negedge clk);
      chk(st & 8'h84, 8'h00);
      wait_rdy();
      chk(8'(n_wr), 8'h01);
      $display("test write suspend done");
      lk = ~23'h000208;
      repeat (3) @(negedge clk);
      n_ers = 0;
      blk_q.delete();
      wr(8'h30, 20'h0);
      wr(8'hD0, 20'h0);
      wr(SUSP, 20'h0);
      repeat (20) @(negedge clk);
      chk(st & 8'h40, 8'h00);
      wait_rdy();
      chk(8'(n_ers), 8'h02);
      chk({3'h0, blk_q[0]}, 8'h03);
      chk({3'h0, blk_q[1]}, 8'h09);
      chk(st & 8'h3E, 8'h00);
      $display("test chip erase done");
      print_verdict();
   end
endmodule
`default_nettype wire
